// >>> accel_cfg_checker_assertions.sv
// Port checker for the readout and idle configuration block.
module accel_cfg_checker
(
   input wire clk_sys,
   input wire nrst,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata_q,
   input wire boot_config_strap,
   input wire wake_pin,
   input wire motion_level_pin,
   input wire odr_tick_q,
   input wire hibernate_q,
   input wire booting_q,
   input wire active_forced_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // True when the bus addresses one of the seven mapped registers.
   // The two magnitude result registers are readable as well.
   wire mapped = (reg_addr >= 8'h19) && (reg_addr <= 8'h1D) ||
      reg_addr == 8'h0A || reg_addr == 8'h0B;
   // Shutdown write that the strap-low device must act on.
   wire sd_wr = reg_wr && reg_addr == 8'h19 && reg_wdata[0];
   ////////////////////////////////////////////////////////////////////
   a_unmapped_reads_zero: assert property (reg_rd && !mapped
      |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
   a_nibble_top_zero: assert property (reg_rd &&
      (reg_addr == 8'h1B || reg_addr == 8'h1D) |=> reg_rdata_q[7:4] == 4'h0)
      else $error("off-time high register top bits set");
   a_cfg_top_zero: assert property (reg_rd && reg_addr == 8'h19
      |=> reg_rdata_q[7:5] == 3'h0) else $error("config top bits set");
   a_shutdown_enters: assert property (sd_wr && !boot_config_strap
      && !hibernate_q && !booting_q |=> hibernate_q)
      else $error("shutdown write did not hibernate");
   a_wake_on_edge: assert property (hibernate_q &&
      !boot_config_strap && $changed(wake_pin) |-> ##[1:6] !hibernate_q)
      else $error("wake edge ignored");
   a_no_quiet_wake: assert property ((hibernate_q &&
      !boot_config_strap && $stable(wake_pin))[*6] |=> hibernate_q)
      else $error("left hibernate without wake edge");
   a_motion_low_sleeps: assert property (boot_config_strap &&
      !motion_level_pin |-> ##[0:8] hibernate_q)
      else $error("motion low did not hibernate");
   a_motion_high_wakes: assert property (boot_config_strap &&
      motion_level_pin && hibernate_q |-> ##[1:8]
      (active_forced_q && !hibernate_q)) else $error("motion high no wake");
   a_tick_one_cycle: assert property (odr_tick_q
      |=> !odr_tick_q) else $error("period tick longer than one cycle");
   // Main scenarios that the bench is expected to reach.
   c_hibernate: cover property ($rose(hibernate_q));
   c_forced: cover property ($rose(active_forced_q));
   c_tick: cover property (odr_tick_q);
endmodule // accel_cfg_checker

bind accel_readout_and_idle_config accel_cfg_checker chk (.*);

// >>> accel_cfg_map.vh
// Register offsets, field positions, reset values and timing counts.
`ifndef ACCEL_CFG_MAP_VH
`define ACCEL_CFG_MAP_VH
`define SENSOR_CONFIG_FIVE_ADDR 8'h19
`define ACTIVE_OFFTIME_LOW_ADDR 8'h1A
`define ACTIVE_OFFTIME_HIGH_ADDR 8'h1B
`define REST_OFFTIME_LOW_ADDR 8'h1C
`define REST_OFFTIME_HIGH_ADDR 8'h1D
`define MAG_EN_BIT 4
`define X_SKIP_BIT 3
`define Y_SKIP_BIT 2
`define Z_SKIP_BIT 1
`define SHUTDOWN_BIT 0
`define CFG5_RESET 8'h00
`define OFFTIME_RESET 8'h00
`define CFG5_USED_MASK 8'h1F
`define HIGH_USED_MASK 8'h0F
// Off-time step in nanoseconds (312.5 us) and clock period in ns.
`define OFFTIME_STEP_NS 312500
`define CLK_PERIOD_NS 4
`define OFFTIME_STEP_CYCLES (`OFFTIME_STEP_NS / `CLK_PERIOD_NS)
// Result register addresses walked by the auto-increment pointer.
`define X_RESULT_LOW_ADDR 8'h04
`define Y_RESULT_LOW_ADDR 8'h06
`define Z_RESULT_LOW_ADDR 8'h08
`define MAG_RESULT_LOW_ADDR 8'h0A
`define MAG_RESULT_HIGH_ADDR 8'h0B
`endif

// >>> accel_readout_and_idle_config.v
// Readout and idle configuration registers with hibernate control.
//
// Overview of operation
// RULE_01 - Magnitude enable bit gates magnitude computation.
// RULE_02 - Magnitude registers join auto-increment only when enabled.
// RULE_03 - Magnitude feeds change detector when selected.
// RULE_04 - X skip bit drops x from sequence.
// RULE_05 - Y skip bit drops y from sequence.
// RULE_06 - Z skip bit drops z from sequence.
// RULE_07 - Shutdown bit enters hibernate, registers lost.
// RULE_08 - Shutdown clear: follow power settings.
// RULE_09 - Strap low: wake pin edge leaves hibernate.
// RULE_10 - Host waits first boot interval.
// RULE_11 - Strap high: motion pin high wakes active.
// RULE_12 - Host waits second boot interval.
// RULE_13 - Strap high: motion pin low hibernates.
// RULE_14 - Active off time: 1Ah low, 1Bh nibble.
// RULE_15 - Active off time used only in flexible.
// RULE_16 - Active off-time step is 312.5 us.
// RULE_17 - Active period is off time plus measurement.
// RULE_18 - Rest off time from 1Ch/1Dh, flexible only.
// RULE_19 - Rest off-time step is 312.5 us.
// RULE_20 - Rest period is off time plus measurement.
// RULE_21 - Unused upper bits read zero, no effect.
`include "accel_cfg_map.vh"
module accel_readout_and_idle_config
#(
   parameter STEP_CYCLES = `OFFTIME_STEP_CYCLES,
   parameter BOOT_WAIT_FIRST_CYCLES = 1000,
   parameter BOOT_WAIT_SECOND_CYCLES = 1000
)
(
   input wire clk_sys,
   input wire nrst,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_q,
   input wire autoinc_step,
   input wire [7:0] autoinc_addr,
   output reg [7:0] autoinc_next_q,
   input wire boot_config_strap,
   input wire wake_pin,
   input wire motion_level_pin,
   input wire [1:0] active_power_setting,
   input wire [1:0] rest_power_setting,
   input wire rest_mode,
   input wire [15:0] active_meas_cycles,
   input wire [15:0] rest_meas_cycles,
   input wire change_detector_mode,
   input wire [11:0] magnitude_in,
   input wire [11:0] axis_select_in,
   output reg [11:0] change_detector_input_q,
   output reg [11:0] magnitude_result_q,
   output reg odr_tick_q,
   output reg hibernate_q,
   output reg booting_q,
   output reg active_forced_q
);
   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   wire strap_s; // Boot strap level after synchronisation.
   wire wake_s; // Select/wake pin after synchronisation.
   wire motion_s; // Motion pin after synchronisation.

   sync_2ff u_sync_strap
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .din(boot_config_strap),
      .dout(strap_s)
   );
   sync_2ff u_sync_wake
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .din(wake_pin),
      .dout(wake_s)
   );
   sync_2ff u_sync_motion
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .din(motion_level_pin),
      .dout(motion_s)
   );

   ////////////////////////////////////////////////////////////////////
   // Register storage.
   reg [4:0] cfg5_q; // Used bits of sensor_config_five.
   reg [7:0] act_low_q; // active_offtime_low.
   reg [3:0] act_high_q; // Nibble of active_offtime_high.
   reg [7:0] rest_low_q; // rest_offtime_low.
   reg [3:0] rest_high_q; // Nibble of rest_offtime_high.
   reg wake_ref_q; // Wake pin level when shutdown was written.
   reg [15:0] boot_cnt_q; // Boot wait counter.
   reg strap_q; // Strap captured after reset release.
   reg strap_valid_q; // Strap has been captured.
   reg [1:0] strap_wait_q; // Edges since reset release, for the strap.
   // Reset image of the five used configuration bits.
   localparam [7:0] CFG5_INIT = `CFG5_RESET;
   wire magnitude_calc_enable = cfg5_q[`MAG_EN_BIT];
   wire x_axis_readout_skip = cfg5_q[`X_SKIP_BIT];
   wire y_axis_readout_skip = cfg5_q[`Y_SKIP_BIT];
   wire z_axis_readout_skip = cfg5_q[`Z_SKIP_BIT];
   wire [11:0] act_off = {act_high_q, act_low_q}; // [RULE_14]
   wire [11:0] rest_off = {rest_high_q, rest_low_q}; // [RULE_18]
   // Registers lose content on hibernate entry, like a power loss.
   wire wipe = hibernate_q;
   wire [15:0] boot_len = strap_q ? BOOT_WAIT_SECOND_CYCLES[15:0] :
      BOOT_WAIT_FIRST_CYCLES[15:0];

   // Strap is a level sampled once after reset; it never changes live.
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         strap_q <= 1'b0;
         strap_valid_q <= 1'b0;
         strap_wait_q <= 2'h0;
      end
      else if (!strap_valid_q)
      begin
         // The synchroniser leaves reset holding zero, so wait until its
         // second stage carries the real pin level before capturing.
         strap_wait_q <= strap_wait_q + 2'h1;
         if (strap_wait_q == 2'h2)
         begin
            strap_q <= strap_s;
            strap_valid_q <= 1'b1;
         end
      end
   end

   // Register writes; host writes are ignored while hibernating or booting.
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cfg5_q <= CFG5_INIT[4:0];
         act_low_q <= `OFFTIME_RESET;
         act_high_q <= 4'h0;
         rest_low_q <= `OFFTIME_RESET;
         rest_high_q <= 4'h0;
      end
      else if (wipe)
      begin
         cfg5_q <= CFG5_INIT[4:0]; // [RULE_07]
         act_low_q <= `OFFTIME_RESET;
         act_high_q <= 4'h0;
         rest_low_q <= `OFFTIME_RESET;
         rest_high_q <= 4'h0;
      end
      else if (reg_wr && !booting_q)
      begin
         case (reg_addr)
            `SENSOR_CONFIG_FIVE_ADDR: cfg5_q <= reg_wdata[4:0]; // [RULE_21]
            `ACTIVE_OFFTIME_LOW_ADDR: act_low_q <= reg_wdata;
            `ACTIVE_OFFTIME_HIGH_ADDR: act_high_q <= reg_wdata[3:0];
            `REST_OFFTIME_LOW_ADDR: rest_low_q <= reg_wdata;
            `REST_OFFTIME_HIGH_ADDR: rest_high_q <= reg_wdata[3:0];
            default: cfg5_q <= cfg5_q;
         endcase
      end
   end

   // Read data; unused upper bits and unmapped addresses return zero.
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         reg_rdata_q <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `SENSOR_CONFIG_FIVE_ADDR: reg_rdata_q <= {3'h0, cfg5_q}; // [RULE_21]
            `ACTIVE_OFFTIME_LOW_ADDR: reg_rdata_q <= act_low_q;
            `ACTIVE_OFFTIME_HIGH_ADDR: reg_rdata_q <= {4'h0, act_high_q};
            `REST_OFFTIME_LOW_ADDR: reg_rdata_q <= rest_low_q;
            `REST_OFFTIME_HIGH_ADDR: reg_rdata_q <= {4'h0, rest_high_q};
            `MAG_RESULT_LOW_ADDR: reg_rdata_q <= magnitude_result_q[7:0];
            `MAG_RESULT_HIGH_ADDR:
               reg_rdata_q <= {4'h0, magnitude_result_q[11:8]};
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Hibernate control.
   // Strap low: shutdown write enters, wake pin edge leaves.
   // Strap high: motion pin level decides directly.
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         hibernate_q <= 1'b0;
         wake_ref_q <= 1'b0;
         booting_q <= 1'b0;
         boot_cnt_q <= 16'h0000;
         active_forced_q <= 1'b0;
      end
      else if (strap_valid_q && strap_q)
      begin
         if (!motion_s)
         begin
            hibernate_q <= 1'b1; // [RULE_13]
            booting_q <= 1'b0;
            active_forced_q <= 1'b0;
         end
         else if (hibernate_q)
         begin
            hibernate_q <= 1'b0; // [RULE_11]
            booting_q <= 1'b1;
            boot_cnt_q <= 16'h0000;
            active_forced_q <= 1'b1;
         end
         else if (booting_q)
         begin
            boot_cnt_q <= boot_cnt_q + 16'h0001;
            if (boot_cnt_q == boot_len - 16'h0001)
               booting_q <= 1'b0; // [RULE_12]
         end
      end
      else
      begin
         active_forced_q <= 1'b0;
         if (!hibernate_q && !booting_q && reg_wr &&
            reg_addr == `SENSOR_CONFIG_FIVE_ADDR &&
            reg_wdata[`SHUTDOWN_BIT])
         begin
            hibernate_q <= 1'b1; // [RULE_07]
            wake_ref_q <= wake_s;
         end
         else if (hibernate_q && wake_s != wake_ref_q)
         begin
            hibernate_q <= 1'b0; // [RULE_09]
            booting_q <= 1'b1;
            boot_cnt_q <= 16'h0000;
         end
         else if (booting_q)
         begin
            boot_cnt_q <= boot_cnt_q + 16'h0001;
            if (boot_cnt_q == boot_len - 16'h0001)
               booting_q <= 1'b0; // [RULE_10]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Measurement period: measurement time, then off time in flexible.
   wire flex = rest_mode ? rest_power_setting[1] :
      active_power_setting[1]; // [RULE_15] [RULE_18]
   wire [11:0] off_sel = rest_mode ? rest_off : act_off;
   wire [15:0] meas_len = rest_mode ? rest_meas_cycles : active_meas_cycles;
   wire run = !hibernate_q && !booting_q; // [RULE_08]
   reg meas_q; // Measurement phase in progress.
   reg [15:0] meas_cnt_q; // Measurement cycle counter.
   reg off_start_q; // Starts the off-time timer.
   wire off_busy; // Off time still running.
   wire off_done; // Off time finished.

   offtime_timer #(.STEP_CYCLES(STEP_CYCLES)) u_offtime
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .start(off_start_q),
      .steps(off_sel), // [RULE_16] [RULE_19]
      .busy_q(off_busy),
      .done_q(off_done)
   );

   // Period is measurement then off time; the tick marks each measurement end.
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         meas_q <= 1'b0;
         meas_cnt_q <= 16'h0000;
         off_start_q <= 1'b0;
         odr_tick_q <= 1'b0;
      end
      else
      begin
         off_start_q <= 1'b0;
         odr_tick_q <= 1'b0;
         if (!run)
            meas_q <= 1'b0;
         else if (!meas_q && !off_busy && !off_start_q)
         begin
            meas_q <= 1'b1;
            meas_cnt_q <= 16'h0000;
         end
         else if (meas_q)
         begin
            meas_cnt_q <= meas_cnt_q + 16'h0001;
            if (meas_cnt_q + 16'h0001 >= meas_len)
            begin
               meas_q <= 1'b0;
               odr_tick_q <= 1'b1;
               off_start_q <= flex; // [RULE_17] [RULE_20]
            end
         end
      end
   end

   // Magnitude latched each tick only when enabled; feeds detector when change_detector_mode is set.
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         magnitude_result_q <= 12'h000;
         change_detector_input_q <= 12'h000;
      end
      else
      begin
         if (odr_tick_q && magnitude_calc_enable)
            magnitude_result_q <= magnitude_in; // [RULE_01]
         change_detector_input_q <= change_detector_mode ?
            magnitude_result_q : axis_select_in; // [RULE_03]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Auto-increment pointer: skips disabled results.
   reg [7:0] nxt; // Candidate next address.
   always @*
   begin
      nxt = autoinc_addr + 8'h01;
      if (nxt == `X_RESULT_LOW_ADDR && x_axis_readout_skip)
         nxt = `Y_RESULT_LOW_ADDR; // [RULE_04]
      if (nxt == `Y_RESULT_LOW_ADDR && y_axis_readout_skip)
         nxt = `Z_RESULT_LOW_ADDR; // [RULE_05]
      if (nxt == `Z_RESULT_LOW_ADDR && z_axis_readout_skip)
         nxt = `MAG_RESULT_LOW_ADDR; // [RULE_06]
      if (nxt == `MAG_RESULT_LOW_ADDR && !magnitude_calc_enable)
         nxt = `MAG_RESULT_HIGH_ADDR + 8'h01; // [RULE_02]
   end

   // Next address registered on each step request.
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         autoinc_next_q <= 8'h00;
      else if (autoinc_step)
         autoinc_next_q <= nxt;
   end
endmodule // accel_readout_and_idle_config

// >>> accel_readout_and_idle_config_tb.sv
// Self-checking bench for the readout and idle configuration block.
module accel_readout_and_idle_config_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // Short step keeps the long off-time counts quick to simulate.
   localparam int STEP = 4;
   logic clk_sys = 1'b0, nrst = 1'b0, autoinc_step = 1'b0, ok;
   logic boot_config_strap = 1'b0, rest_mode = 1'b0;
   logic change_detector_mode = 1'b0;
   logic [7:0] autoinc_addr = 8'h00, d;
   logic [1:0] active_power_setting = 2'b00, rest_power_setting = 2'b00;
   logic [15:0] active_meas_cycles = 16'h000A, rest_meas_cycles = 16'h0006;
   logic [11:0] magnitude_in = 12'h000, axis_select_in = 12'h000;
   wire reg_wr, reg_rd, wake_pin, motion_level_pin;
   wire [7:0] reg_addr, reg_wdata, reg_rdata_q, autoinc_next_q;
   wire [11:0] change_detector_input_q, magnitude_result_q;
   wire odr_tick_q, hibernate_q, booting_q, active_forced_q;
   int failures = 0, checked = 0, n;
   // Rows: kind (00 register, 01 pointer), address, data, expected.
   logic [31:0] rows [14] = '{32'h0019FE1E, 32'h001AA5A5, 32'h001BFF0F,
      32'h001C3C3C, 32'h001DF707, 32'h0018AA00, 32'h00205500,
      32'h01030004, 32'h01030806, 32'h01050006, 32'h01050408,
      32'h0107120A, 32'h0109100A, 32'h0109000C};
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

   accel_readout_and_idle_config #(.STEP_CYCLES(STEP),
      .BOOT_WAIT_FIRST_CYCLES(8), .BOOT_WAIT_SECOND_CYCLES(8)) dut (.*);
   host_model host (.*);
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #2 clk_sys = ~clk_sys;
   end
   task give_verdict;
      if (failures == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Reset with the strap already at its level for the whole pulse.
   task do_reset(input logic s);
      nrst = 1'b0;
      boot_config_strap = s;
      repeat (5) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
   endtask
   // Cycles up to the next period tick; a missing tick ends the run.
   task wait_tick(output int k);
      k = 0;
      do
      begin
         @(posedge clk_sys);
         #1;
         k++;
      end while (odr_tick_q !== 1'b1 && k < 3000);
      if (k >= 3000)
      begin
         failures++;
         give_verdict();
      end
   endtask
   // The first interval may straddle a configuration change.
   task period;
      repeat (3) wait_tick(n);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      do_reset(1'b0);
      for (int a = 8'h19; a <= 8'h1D; a++)
      begin
         host.rd(a[7:0], d);
         `CHK(d, 8'h00)
      end
      foreach (rows[i])
      begin
         if (rows[i][31:24] == 8'h00)
         begin
            host.wr(rows[i][23:16], rows[i][15:8]);
            host.rd(rows[i][23:16], d);
         end
         else
         begin
            host.wr(8'h19, rows[i][15:8]);
            @(posedge clk_sys);
            #1;
            autoinc_addr = rows[i][23:16];
            autoinc_step = 1'b1;
            @(posedge clk_sys);
            #1;
            autoinc_step = 1'b0;
            d = autoinc_next_q;
         end
         `CHK(d, rows[i][7:0])
      end
      // Off time split across two registers, only counted when flexible.
      host.wr(8'h1A, 8'h00);
      host.wr(8'h1B, 8'h01);
      active_power_setting = 2'b10;
      period();
      `CHK(n - 10 - 256 * STEP inside {[0:4]}, 1'b1)
      active_power_setting = 2'b01;
      period();
      `CHK(n - 10 inside {[0:4]}, 1'b1)
      host.wr(8'h1C, 8'h03);
      host.wr(8'h1D, 8'hF0);
      rest_power_setting = 2'b11;
      rest_mode = 1'b1;
      period();
      `CHK(n - 6 - 3 * STEP inside {[0:4]}, 1'b1)
      // Magnitude kept only while enabled; detector input follows mode.
      host.wr(8'h19, 8'h10);
      magnitude_in = 12'hABC;
      axis_select_in = 12'h456;
      change_detector_mode = 1'b1;
      period();
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(magnitude_result_q, 12'hABC)
      `CHK(change_detector_input_q, 12'hABC)
      host.rd(8'h0A, d);
      `CHK(d, 8'hBC)
      host.rd(8'h0B, d);
      `CHK(d, 8'h0A)
      host.wr(8'h19, 8'h00);
      magnitude_in = 12'h123;
      change_detector_mode = 1'b0;
      period();
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(magnitude_result_q, 12'hABC)
      `CHK(change_detector_input_q, 12'h456)
      // Strap low: shutdown, stay down, then wake on each edge direction.
      for (int j = 0; j < 2; j++)
      begin
         host.wr(8'h19, 8'h1F);
         `CHK(hibernate_q, 1'b1)
         repeat (10) @(posedge clk_sys);
         #1;
         `CHK(hibernate_q, 1'b1)
         host.wake(ok);
         `CHK(ok, 1'b1)
         host.rd(8'h1B, d);
         `CHK(d, 8'h00)
      end
      // Strap high: the motion pin alone moves the device in and out.
      do_reset(1'b1);
      repeat (10) @(posedge clk_sys);
      #1;
      `CHK(hibernate_q, 1'b1)
      host.mot(1'b1, ok);
      `CHK(ok & active_forced_q, 1'b1)
      host.mot(1'b0, ok);
      `CHK(ok, 1'b1)
      give_verdict();
   end
endmodule // accel_readout_and_idle_config_tb

// >>> host_model.sv
// Host controller model: register transfers and the two wake pins.
module host_model
(
   input wire clk_sys,
   input wire [7:0] reg_rdata_q,
   input wire hibernate_q,
   input wire booting_q,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   output logic wake_pin = 1'b0,
   output logic motion_level_pin = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   ////////////////////////////////////////////////////////////////////
   // One-cycle write; address and data are scrambled afterwards so the
   // block never sees a stale value that happens to look valid.
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
   endtask
   // One-cycle read; the data is taken one cycle after the request.
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      v = reg_rdata_q;
   endtask
   // Bounded wait for a settled state with the boot sequence finished.
   task settle(input logic w, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 100 && !ok; i++)
      begin
         @(posedge clk_sys);
         #1;
         ok = hibernate_q === w && booting_q === 1'b0;
      end
   endtask
   // Toggle the wake pin, then stay off the bus until boot is over.
   task wake(output logic ok);
      @(posedge clk_sys);
      #1;
      wake_pin = ~wake_pin;
      settle(1'b0, ok);
   endtask
   // Drive the motion pin and wait for the matching state.
   task mot(input logic v, output logic ok);
      @(posedge clk_sys);
      #1;
      motion_level_pin = v;
      settle(~v, ok);
   endtask
endmodule // host_model

// >>> offtime_timer.v
// Off-time timer: counts a 12-bit number of fixed-length steps.
`include "accel_cfg_map.vh"
module offtime_timer
#(
   parameter STEP_CYCLES = `OFFTIME_STEP_CYCLES
)
(
   input wire clk_sys,
   input wire nrst,
   input wire start,
   input wire [11:0] steps,
   output reg busy_q,
   output reg done_q
);
   reg [16:0] tick_q; // Cycles within the current step.
   reg [11:0] step_q; // Steps left.

   // A zero count still waits one step, so the shortest off time is
   // one step, matching the documented lower end of the range.
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         tick_q <= 17'h00000;
         step_q <= 12'h000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (start)
         begin
            tick_q <= 17'h00000;
            step_q <= (steps == 12'h000) ? 12'h001 : steps;
            busy_q <= 1'b1;
         end
         else if (busy_q)
         begin
            if (tick_q == STEP_CYCLES[16:0] - 17'h00001)
            begin
               tick_q <= 17'h00000;
               if (step_q == 12'h001)
               begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end
               step_q <= step_q - 12'h001;
            end
            else
            begin
               tick_q <= tick_q + 17'h00001;
            end
         end
      end
   end
endmodule // offtime_timer

// >>> sync_2ff.v
// Two-flop synchroniser for a pin level.
module sync_2ff
(
   input wire clk_sys,
   input wire nrst,
   input wire din,
   output wire dout
);
   reg meta_q; // First stage, read only by the second stage.
   reg sync_q; // Second stage, safe for logic.

   // Two stages settle metastability before any logic sees the pin.
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end
   assign dout = sync_q;
endmodule // sync_2ff
